/* File: branch_skip_bitop_execute.sv */
// Purpose: executes skips, flag branches, i/o bit set/clear and logical shifts
// Assumes: fetch presents the word at PC with FETCH_VALID; APB slave for state
// Notes:   i/o space, status flags and work register are held here
// Operation
// - skip next instruction when i/o bit clear
// - skip next instruction when i/o bit set
// - generic branch taken when selected flag set
// - generic branch taken when selected flag clear
// - named branches test zero, carry, negative flags
// - signed branches test negative xor overflow
// - half carry, transfer, overflow branch pairs
// - branches on global interrupt enable flag
// - set one i/o bit in two cycles
// - clear one i/o bit in two cycles
// - shift left, zero in, update flags
// - shift right, zero in, update flags
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "exec_regs.svh"
module branch_skip_bitop_execute #(
    parameter int PC_W = 12
) (
    input  wire logic            CLK,
    input  wire logic            RST_B,
    input  wire logic            FETCH_VALID,
    input  wire logic [15:0]     FETCH_WORD,
    input  wire logic            FETCH_NEXT_LONG,
    output logic                 FETCH_READY,
    output logic [PC_W-1:0]      PC,
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [11:0]     PADDR,
    input  wire logic [31:0]     PWDATA,
    output logic [31:0]          PRDATA,
    output logic                 PREADY,
    output logic                 PSLVERR
);
    exec_pkg::dec_t   dec;
    exec_pkg::state_t state;
    logic [7:0]       io_mem [32];
    logic [7:0]       status;
    logic [7:0]       work;
    logic [1:0]       hold_cnt;
    logic [4:0]       rmw_addr;
    logic [2:0]       rmw_bit;
    logic             rmw_set;
    logic             acc;
    logic             io_bit;
    logic             flag;
    logic             skip_take;
    logic             br_take;
    logic [PC_W-1:0]  off_ext;
    logic [PC_W-1:0]  next_pc;
    logic [7:0]       shift_res;
    logic             shift_c;
    logic             apb_wr;
    logic             apb_acc;
    logic             io_hit;
    logic             hit;
    logic [31:0]      next_rdata;

    // instruction decode
    always_comb begin
        dec.sel  = FETCH_WORD[`F_SEL];
        dec.addr = FETCH_WORD[`F_ADDR];
        dec.off  = FETCH_WORD[`F_OFF];
        case (FETCH_WORD[`F_OPC])
            `OPC_SKIP_CLR: dec.op = exec_pkg::OP_SKIP_CLR;
            `OPC_SKIP_SET: dec.op = exec_pkg::OP_SKIP_SET;
            `OPC_BR_SET:   dec.op = exec_pkg::OP_BR_SET;
            `OPC_BR_CLR:   dec.op = exec_pkg::OP_BR_CLR;
            `OPC_SET_IO:   dec.op = exec_pkg::OP_SET_IO;
            `OPC_CLR_IO:   dec.op = exec_pkg::OP_CLR_IO;
            `OPC_SHL:      dec.op = exec_pkg::OP_SHL;
            `OPC_SHR:      dec.op = exec_pkg::OP_SHR;
            default:       dec.op = exec_pkg::OP_NONE;
        endcase
    end

    assign acc    = FETCH_READY & FETCH_VALID;
    assign io_bit = io_mem[dec.addr][dec.sel];

    // flag selection
    // any status flag by index except bit 4; zero, carry, negative, half, transfer, overflow, enable
    // signed compare
    // select code for the signed flag evaluates n xor v live
    assign flag = (dec.sel == `SEL_SIGNED) ? (status[`FLG_N] ^ status[`FLG_V])
                                           : status[dec.sel];

    // skip on clear or set
    // clear and set variants of the i/o bit test
    assign skip_take = (dec.op == exec_pkg::OP_SKIP_CLR && !io_bit) ||
                       (dec.op == exec_pkg::OP_SKIP_SET && io_bit);

    // flag branch pair
    // set variant on one, clear variant on zero
    assign br_take = (dec.op == exec_pkg::OP_BR_SET && flag) ||
                     (dec.op == exec_pkg::OP_BR_CLR && !flag);

    assign off_ext = {{(PC_W-7){dec.off[`OFF_SIGN]}}, dec.off};

    // program counter target
    always_comb begin
        next_pc = PC + PC_W'(`PC_STEP);
        if (skip_take) begin
            next_pc = PC + (FETCH_NEXT_LONG ? PC_W'(`SKIP_STEP_L) : PC_W'(`SKIP_STEP));
        end else if (br_take) begin
            next_pc = PC + off_ext + PC_W'(`PC_STEP);
        end
    end

    // shift datapath
    always_comb begin
        if (dec.op == exec_pkg::OP_SHL) begin
            shift_res = {work[6:0], 1'b0};
            shift_c   = work[7];
        end else begin
            shift_res = {1'b0, work[7:1]};
            shift_c   = work[0];
        end
    end

    // apb decode
    assign apb_acc = PSEL & PENABLE & PREADY;
    assign apb_wr  = apb_acc & PWRITE;
    assign io_hit  = (PADDR & `IO_WIN_MASK) == `OFS_IO_BASE;
    assign hit     = io_hit || PADDR == `OFS_STATUS || PADDR == `OFS_PC ||
                     PADDR == `OFS_WORK;

    // read data mux
    always_comb begin
        next_rdata = 32'h0;
        if (io_hit) begin
            next_rdata[7:0] = io_mem[PADDR[`IO_IDX]];
        end else if (PADDR == `OFS_STATUS) begin
            next_rdata[7:0] = status;
        end else if (PADDR == `OFS_PC) begin
            next_rdata[PC_W-1:0] = PC;
        end else if (PADDR == `OFS_WORK) begin
            next_rdata[7:0] = work;
        end
    end

    // sequencing of stalls and the read-modify-write cycle
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state       <= exec_pkg::ST_RUN;
            FETCH_READY <= 1'b1;
            hold_cnt    <= 2'd0;
        end else begin
            case (state)
                exec_pkg::ST_RUN: begin
                    if (acc && (skip_take || br_take)) begin
                        state       <= exec_pkg::ST_HOLD;
                        FETCH_READY <= 1'b0;
                        hold_cnt    <= (skip_take && FETCH_NEXT_LONG) ? `HOLD_LONG
                                                                      : `HOLD_SHORT;
                    end else if (acc && (dec.op == exec_pkg::OP_SET_IO ||
                                         dec.op == exec_pkg::OP_CLR_IO)) begin
                        state       <= exec_pkg::ST_RMW;
                        FETCH_READY <= 1'b0;
                    end
                end
                exec_pkg::ST_HOLD: begin
                    hold_cnt <= hold_cnt - 2'd1;
                    if (hold_cnt == `HOLD_SHORT) begin
                        state       <= exec_pkg::ST_RUN;
                        FETCH_READY <= 1'b1;
                    end
                end
                exec_pkg::ST_RMW: begin
                    state       <= exec_pkg::ST_RUN;
                    FETCH_READY <= 1'b1;
                end
                default: begin
                    state       <= exec_pkg::ST_RUN;
                    FETCH_READY <= 1'b1;
                end
            endcase
        end
    end

    // program counter; core update wins over software
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PC <= '0;
        end else if (acc) begin
            PC <= next_pc;
        end else if (apb_wr && PADDR == `OFS_PC) begin
            PC <= PWDATA[PC_W-1:0];
        end
    end

    // status flags and work register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status <= `RST_STATUS;
            work   <= `RST_WORK;
        end else if (acc && (dec.op == exec_pkg::OP_SHL || dec.op == exec_pkg::OP_SHR)) begin
            // left and right shift flags
            // zero, carry, negative, overflow; others kept
            work             <= shift_res;
            status[`FLG_Z]   <= shift_res == 8'h00;
            status[`FLG_C]   <= shift_c;
            status[`FLG_N]   <= shift_res[7];
            status[`FLG_V]   <= shift_res[7] ^ shift_c;
        end else if (apb_wr && PADDR == `OFS_STATUS) begin
            status <= PWDATA[7:0];
        end else if (apb_wr && PADDR == `OFS_WORK) begin
            work <= PWDATA[7:0];
        end
    end

    // bit operation latch taken at acceptance
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rmw_addr <= 5'h00;
            rmw_bit  <= 3'h0;
            rmw_set  <= 1'b0;
        end else if (acc) begin
            rmw_addr <= dec.addr;
            rmw_bit  <= dec.sel;
            rmw_set  <= dec.op == exec_pkg::OP_SET_IO;
        end
    end

    // i/o space; the bit write of the second cycle wins over software
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < 32; i++) begin
                io_mem[i] <= `RST_IO;
            end
        end else if (state == exec_pkg::ST_RMW) begin
            // single bit set or clear
            // other bits and flags untouched
            io_mem[rmw_addr][rmw_bit] <= rmw_set;
        end else if (apb_wr && io_hit) begin
            io_mem[PADDR[`IO_IDX]] <= PWDATA[7:0];
        end
    end

    // apb answer one cycle after the access phase opens
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL & PENABLE & !PREADY;
            PSLVERR <= PSEL & PENABLE & !PREADY & !hit;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA <= next_rdata;
            end
        end
    end

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence stall_one;
        !FETCH_READY ##1 FETCH_READY;
    endsequence
    sequence stall_two;
        !FETCH_READY [*2] ##1 FETCH_READY;
    endsequence

    skip_clear_a: assert property (acc && dec.op == exec_pkg::OP_SKIP_CLR && !io_bit
        |=> PC == $past(PC) + (($past(FETCH_NEXT_LONG)) ? 3'd3 : 3'd2))
        else $error("skip on clear bit moved pc wrongly");
    skip_set_a: assert property (acc && dec.op == exec_pkg::OP_SKIP_SET && io_bit
        |=> PC == $past(PC) + (($past(FETCH_NEXT_LONG)) ? 3'd3 : 3'd2))
        else $error("skip on set bit moved pc wrongly");
    skip_long_a: assert property (acc && skip_take && FETCH_NEXT_LONG |=> stall_two)
        else $error("long skip did not stall two cycles");
    branch_set_a: assert property (acc && dec.op == exec_pkg::OP_BR_SET && flag
        |=> PC == $past(PC) + $past(off_ext) + 1'b1 ##0 stall_one)
        else $error("taken set branch wrong target or timing");
    branch_clr_a: assert property (acc && dec.op == exec_pkg::OP_BR_CLR && flag
        |=> FETCH_READY && PC == $past(PC) + 1'b1)
        else $error("untaken clear branch stalled or jumped");
    signed_ge_a: assert property (acc && dec.op == exec_pkg::OP_BR_CLR &&
        dec.sel == `SEL_SIGNED && status[`FLG_N] == status[`FLG_V] |=> stall_one)
        else $error("signed branch not taken on equal n and v");
    irq_branch_a: assert property (acc && dec.op == exec_pkg::OP_BR_SET &&
        dec.sel == `FLG_I && !status[`FLG_I] |=> FETCH_READY)
        else $error("branch on enable taken with enable clear");
    set_bit_a: assert property (acc && dec.op == exec_pkg::OP_SET_IO
        |=> !FETCH_READY ##1 (FETCH_READY && io_mem[rmw_addr][rmw_bit] && $stable(status)))
        else $error("set bit not done in two cycles");
    clear_bit_a: assert property (acc && dec.op == exec_pkg::OP_CLR_IO
        |=> !FETCH_READY ##1 (FETCH_READY && !io_mem[rmw_addr][rmw_bit]))
        else $error("clear bit not done in two cycles");
    shift_left_a: assert property (acc && dec.op == exec_pkg::OP_SHL
        |=> work == {$past(work[6:0]), 1'b0} && status[`FLG_C] == $past(work[7]) && FETCH_READY)
        else $error("left shift result or carry wrong");
    shift_right_a: assert property (acc && dec.op == exec_pkg::OP_SHR
        |=> work == {1'b0, $past(work[7:1])} && status[`FLG_C] == $past(work[0])
            && !status[`FLG_N])
        else $error("right shift result or flags wrong");
endmodule // branch_skip_bitop_execute

/* File: exec_pkg.sv */
// Purpose: types shared by the execute block
// Assumes: nothing
// Notes:   encodings of the opcodes live in exec_regs.svh
package exec_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_RMW} state_t;
    typedef enum logic [3:0] {OP_NONE, OP_SKIP_CLR, OP_SKIP_SET, OP_BR_SET, OP_BR_CLR,
                              OP_SET_IO, OP_CLR_IO, OP_SHL, OP_SHR} op_t;
    typedef struct packed {
        op_t        op;
        logic [2:0] sel;
        logic [4:0] addr;
        logic [6:0] off;
    } dec_t;
endpackage

/* File: exec_regs.svh */
// Purpose: offsets, field positions, reset values and counts of the execute block
// Assumes: 12-bit APB byte address, 16-bit instruction word
// Notes:   definitions only
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// apb byte offsets
`define OFS_STATUS   12'h000
`define OFS_PC       12'h004
`define OFS_WORK     12'h008
`define OFS_IO_BASE  12'h080
`define IO_WIN_MASK  12'hf80
`define IO_IDX       6:2

// status flag bit positions
`define FLG_C        0
`define FLG_Z        1
`define FLG_N        2
`define FLG_V        3
`define FLG_S        4
`define FLG_H        5
`define FLG_T        6
`define FLG_I        7
// flag select that evaluates n xor v live
`define SEL_SIGNED   3'h4

// instruction fields
`define F_OPC        15:12
`define F_SEL        10:8
`define F_ADDR       4:0
`define F_OFF        6:0
`define OFF_SIGN     6

// opcodes
`define OPC_SKIP_CLR 4'h0
`define OPC_SKIP_SET 4'h1
`define OPC_BR_SET   4'h2
`define OPC_BR_CLR   4'h3
`define OPC_SET_IO   4'h4
`define OPC_CLR_IO   4'h5
`define OPC_SHL      4'h6
`define OPC_SHR      4'h7

// program counter steps and stall counts
`define PC_STEP      2'd1
`define SKIP_STEP    2'd2
`define SKIP_STEP_L  2'd3
`define HOLD_SHORT   2'd1
`define HOLD_LONG    2'd2

// reset values
`define RST_STATUS   8'h00
`define RST_WORK     8'h00
`define RST_IO       8'h00
`endif

/* File: fetch_model.sv */
// Purpose: instruction fetch path model for the execute block
// Assumes: the word at pc is shown as soon as the core moves pc
// Notes:   mem and long_tag are loaded by the bench; idle lines show the inverted word
`timescale 1ns/10ps
module fetch_model (
    input  wire logic        run,
    input  wire logic [11:0] pc,
    output logic             valid,
    output logic [15:0]      word,
    output logic             next_long
);
    logic [15:0] mem      [0:4095];
    logic        long_tag [0:4095];

    // program memory starts as no-op words
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 16'h8000;
            long_tag[i] = 1'b0;
        end
    end

    // present the addressed word; inverted lines while not valid so stale data never matches
    always_comb begin
        valid = run;
        word = run ? mem[pc] : ~mem[pc];
        next_long = run ? long_tag[pc] : ~long_tag[pc];
    end
endmodule // fetch_model

/* File: tb_top.sv */
// Purpose: self-checking bench for the execute block
// Assumes: fetch is paused between instructions so apb can set pc and flags
// Notes:   one instruction per run; stall counted as cycles with fetch ready low
`timescale 1ns/10ps
`include "exec_regs.svh"
module tb_top;
    logic        clk;
    logic        rst_b;
    logic        run;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fvalid;
    logic [15:0] fword;
    logic        flong;
    logic        fready;
    logic [11:0] pc;
    int          bad_count;
    int          compares;

    branch_skip_bitop_execute #(.PC_W(12)) branch_skip_bitop_execute_inst (
        .CLK(clk), .RST_B(rst_b), .FETCH_VALID(fvalid), .FETCH_WORD(fword),
        .FETCH_NEXT_LONG(flong), .FETCH_READY(fready), .PC(pc), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    fetch_model fetch_model_inst (
        .run(run), .pc(pc), .valid(fvalid), .word(fword), .next_long(flong));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        compares++;
        if (got != exp) begin
            bad_count++;
            $display("[ERR] %0t cycles %0d expected %0d", $time, got, exp);
        end
    endtask

    // one apb transfer; pready, read data and error are all taken at the same rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t apb answer missing", $time);
            complete_run();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // run one instruction from start, then check pc, stall length and flags
    task automatic exec(input logic [15:0] w, input logic lg, input logic [7:0] st,
                        input logic [11:0] start, input logic [11:0] exp_pc,
                        input int exp_stall, input logic [7:0] exp_st);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, `OFS_STATUS, {24'h0, st}, r, e);
        apb(1'b1, `OFS_PC, {20'h0, start}, r, e);
        fetch_model_inst.mem[start] = w;
        fetch_model_inst.long_tag[start] = lg;
        @(posedge clk) run <= 1'b1;
        @(posedge clk) run <= 1'b0;
        #1 chk_val({20'h0, pc}, {20'h0, exp_pc});
        n = 0;
        while (fready !== 1'b1 && n < 5) begin
            @(posedge clk);
            #1 n++;
        end
        if (fready !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t fetch ready never returned", $time);
            complete_run();
        end
        chk_cnt(n, exp_stall);
        apb(1'b0, `OFS_STATUS, 32'h0, r, e);
        chk_val(r, {24'h0, exp_st});
    endtask

    task automatic reset_check();
        logic [31:0] r;
        logic        e;
        chk_val({31'h0, fready}, 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0, r, e);
        chk_val(r, 32'h0);
        apb(1'b0, `OFS_WORK, 32'h0, r, e);
        chk_val(r, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0, r, e);
        chk_val(r, 32'h0);
        apb(1'b0, 12'h040, 32'h0, r, e);
        chk_val({r[30:0], e}, 32'h1);
    endtask

    task automatic branch_table();
        logic [7:0] st;
        logic       tk;
        for (int s = 0; s < 8; s++)
            for (int v = 0; v < 2; v++)
                for (int o = 2; o < 4; o++) begin
                    st = (v == 1) ? (8'h01 << ((s == 4) ? 2 : s)) : 8'h00;
                    tk = ((o == 2) == (v == 1));
                    exec({4'(o), 1'b0, 3'(s), 1'b0, 7'h7e}, 1'b0, st, 12'h010,
                         tk ? 12'h00f : 12'h011, tk ? 1 : 0, st);
                end
        exec({4'h3, 1'b0, 3'h4, 1'b0, 7'h3f}, 1'b0, 8'h0c, 12'h020, 12'h060, 1, 8'h0c);
        exec({4'h2, 1'b0, 3'h4, 1'b0, 7'h3f}, 1'b0, 8'h0c, 12'h020, 12'h021, 0, 8'h0c);
    endtask

    task automatic skip_table();
        logic [31:0] r;
        logic        e;
        logic        sk;
        for (int o = 0; o < 2; o++)
            for (int b = 0; b < 2; b++)
                for (int lg = 0; lg < 2; lg++) begin
                    apb(1'b1, 12'h08c, (b == 1) ? 32'h20 : 32'hdf, r, e);
                    sk = (o == 0) ? (b == 0) : (b == 1);
                    exec({4'(o), 1'b0, 3'h5, 3'h0, 5'h03}, 1'(lg), 8'h3c, 12'h100,
                         sk ? ((lg == 1) ? 12'h103 : 12'h102) : 12'h101,
                         sk ? lg + 1 : 0, 8'h3c);
                end
    endtask

    task automatic bit_ops();
        logic [31:0] r;
        logic        e;
        apb(1'b1, 12'h0fc, 32'h5a, r, e);
        exec({4'h4, 1'b0, 3'h0, 3'h0, 5'h1f}, 1'b0, 8'ha5, 12'h7fe, 12'h7ff, 1, 8'ha5);
        apb(1'b0, 12'h0fc, 32'h0, r, e);
        chk_val(r, 32'h5b);
        exec({4'h5, 1'b0, 3'h6, 3'h0, 5'h1f}, 1'b0, 8'h5a, 12'hfff, 12'h000, 1, 8'h5a);
        apb(1'b0, 12'h0fc, 32'h0, r, e);
        chk_val(r, 32'h1b);
        apb(1'b0, 12'h0f8, 32'h0, r, e);
        chk_val(r, 32'h0);
    endtask

    // expected result and flags of a logical shift: v is n xor c, upper flags kept
    function automatic logic [15:0] shift_exp(input logic lf, input logic [7:0] d,
                                              input logic [7:0] st);
        logic [7:0] q;
        logic       c;
        q = lf ? {d[6:0], 1'b0} : {1'b0, d[7:1]};
        c = lf ? d[7] : d[0];
        return {q, st[7:4], q[7] ^ c, q[7], q == 8'h00, c};
    endfunction

    task automatic shifts();
        logic [8:0]  cases [5] = '{9'h181, 9'h180, 9'h140, 9'h001, 9'h080};
        logic [31:0] r;
        logic        e;
        logic [15:0] x;
        for (int i = 0; i < 5; i++) begin
            x = shift_exp(cases[i][8], cases[i][7:0], 8'hfa);
            apb(1'b1, `OFS_WORK, {24'h0, cases[i][7:0]}, r, e);
            exec({cases[i][8] ? 4'h6 : 4'h7, 12'h000}, 1'b0, 8'hfa, 12'h200, 12'h201, 0,
                 x[7:0]);
            apb(1'b0, `OFS_WORK, 32'h0, r, e);
            chk_val(r, {24'h0, x[15:8]});
        end
    endtask

    // reset, then each scenario in turn
    initial begin
        bad_count = 0;
        compares = 0;
        rst_b = 1'b0;
        run = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        reset_check();
        branch_table();
        skip_table();
        bit_ops();
        shifts();
        complete_run();
    end
endmodule // tb_top
